// ==== ssf_defines.svh ====
`ifndef SSF_DEFINES_SVH
`define SSF_DEFINES_SVH

// register offsets (byte addresses)
`define SSF_STATUS_ADDR 4'h0
`define SSF_CTRL_ADDR 4'h4
`define SSF_ADDR_W 4
// status bit positions
`define SSF_TDE_BIT 7
`define SSF_RDF_BIT 6
`define SSF_ORE_BIT 5
`define SSF_FRE_BIT 4
`define SSF_PRE_BIT 3
`define SSF_TX_END_FLAG_BIT 2
`define SSF_MPR_BIT 1
`define SSF_MPT_BIT 0
// reset value of the status register
`define SSF_STATUS_RST 8'h84
// control bit positions
`define SSF_TE_BIT 0
`define SSF_RE_BIT 1
`define SSF_SYNC_BIT 2
`define SSF_MP_BIT 3
`define SSF_ODD_BIT 4
`define SSF_RIE_BIT 5
`define SSF_CTRL_RST 8'h00

`endif

// ==== ssf_line_model.sv ====
`timescale 1ns/1ps
// shift engines of both directions, as the status block sees them
module ssf_line_model
   import ssf_pkg::*;
(
   // clock and pace
   input wire logic clk_i,
   input wire logic slow_i,
   // transmit side
   input wire logic tx_start_i,
   output logic tx_load_o = 1'b0,
   output logic tx_last_bit_o = 1'b0,
   // receive side
   output logic rx_done_o = 1'b0,
   output ssf_rxchar_s rx_char_o = '0
);
   always @(posedge clk_i) begin
      if (tx_start_i) begin
         repeat (slow_i ? 9 : 2) @(posedge clk_i);
         tx_load_o <= 1'b1;
         @(posedge clk_i);
         tx_load_o <= 1'b0;
         repeat (slow_i ? 20 : 4) @(posedge clk_i);
         tx_last_bit_o <= 1'b1;
         @(posedge clk_i);
         tx_last_bit_o <= 1'b0;
      end
   end
   // one character; idle lines carry the inverse, never stale data
   task automatic send(input ssf_rxchar_s c);
      @(posedge clk_i);
      rx_done_o <= 1'b1;
      rx_char_o <= c;
      @(posedge clk_i);
      rx_done_o <= 1'b0;
      rx_char_o <= ~c;
   endtask : send
endmodule : ssf_line_model

// ==== ssf_pkg.sv ====
package ssf_pkg;
   // character handed over by the receive shift engine
   typedef struct packed {
      logic [7:0] data;
      logic parity;
      logic stop1;
      logic mpbit;
   } ssf_rxchar_s;
   // wishbone request
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ssf_wbreq_s;
endpackage : ssf_pkg

// ==== ssf_status.sv ====
`timescale 1ns/1ps
`include "ssf_defines.svh"

module ssf_status
   import ssf_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic standby_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // transmit engine
   input wire logic tx_load_i,
   input wire logic tx_last_bit_i,
   output logic tx_start_o,
   output logic tx_mpbit_o,
   output logic tx_run_ok_o,
   // receive engine
   input wire logic rx_done_i,
   input wire ssf_rxchar_s rx_char_i,
   input wire logic dma_rd_i,
   output logic [7:0] rx_data_o,
   output logic rx_run_ok_o,
   // interrupt requests to the interrupt controller
   output logic rx_full_irq_o,
   output logic rx_error_irq_o
);

   // -------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------
   logic [7:0] stat_r;
   logic [7:0] ctrl_r;
   logic [4:0] armed_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic [7:0] rxd_r;
   logic start_r;
   logic rxirq_r;
   logic erirq_r;

   wire acc = cyc_i && stb_i && !ack_r;
   wire hit_stat = adr_i == `SSF_STATUS_ADDR;
   wire hit_ctrl = adr_i == `SSF_CTRL_ADDR;
   wire wr_stat = acc && we_i && hit_stat && sel_i[0];
   wire wr_ctrl = acc && we_i && hit_ctrl && sel_i[0];
   wire rd_stat = acc && !we_i && hit_stat;
   wire te = ctrl_r[`SSF_TE_BIT];
   wire re = ctrl_r[`SSF_RE_BIT];
   wire sync_md = ctrl_r[`SSF_SYNC_BIT];
   wire mp_md = ctrl_r[`SSF_MP_BIT];
   wire odd_par = ctrl_r[`SSF_ODD_BIT];
   wire rie = ctrl_r[`SSF_RIE_BIT];
   wire te_fall = wr_ctrl && te && !dat_i[`SSF_TE_BIT];
   wire init = rst_i || standby_i;

   // clearable flags packed as tde, rdf, ore, fre, pre
   wire [4:0] clr_flags = stat_r[7:3];
   wire [4:0] wclr = {5{wr_stat}} & armed_r & ~dat_i[7:3];
   wire err_any = stat_r[`SSF_ORE_BIT] | stat_r[`SSF_FRE_BIT]
      | stat_r[`SSF_PRE_BIT];
   wire rx_ok = re && !err_any;
   wire rx_take = rx_done_i && rx_ok;
   wire par_bad = !sync_md
      && ((^rx_char_i.data ^ rx_char_i.parity) != odd_par);
   wire frm_bad = !sync_md && !rx_char_i.stop1;
   wire ovr = rx_take && stat_r[`SSF_RDF_BIT];
   wire good = rx_take && !ovr && !par_bad && !frm_bad;

   // -------------------------------------------------------------
   // status next value
   // -------------------------------------------------------------
   logic [7:0] stat_nxt;
   always_comb begin
      stat_nxt = stat_r;
      stat_nxt[7:3] = clr_flags & ~wclr;
      // tx end clears with tx empty
      if (wclr[4] && te) begin
         stat_nxt[`SSF_TX_END_FLAG_BIT] = 1'b0;
      end
      if (dma_rd_i) begin
         stat_nxt[`SSF_RDF_BIT] = 1'b0;
      end
      // tx empty set events (set wins)
      if (te_fall || tx_load_i || !te) begin
         stat_nxt[`SSF_TDE_BIT] = 1'b1;
      end
      if (te_fall || (tx_last_bit_i && stat_r[`SSF_TDE_BIT])) begin
         stat_nxt[`SSF_TX_END_FLAG_BIT] = 1'b1;
      end
      if (ovr) begin
         stat_nxt[`SSF_ORE_BIT] = 1'b1;
      end
      if (good) begin
         stat_nxt[`SSF_RDF_BIT] = 1'b1;
      end
      if (rx_take && !ovr && frm_bad) begin
         stat_nxt[`SSF_FRE_BIT] = 1'b1;
      end
      if (rx_take && !ovr && par_bad) begin
         stat_nxt[`SSF_PRE_BIT] = 1'b1;
      end
      if (rx_take && !ovr && mp_md && !sync_md) begin
         stat_nxt[`SSF_MPR_BIT] = rx_char_i.mpbit;
      end
      if (wr_stat) begin
         stat_nxt[`SSF_MPT_BIT] = dat_i[`SSF_MPT_BIT];
      end
   end

   // arm markers on read of one
   logic [4:0] armed_nxt;
   assign armed_nxt = wr_stat ? 5'h00
      : (rd_stat ? (armed_r | clr_flags) : armed_r) & clr_flags;

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   // reset and standby value
   always_ff @(posedge clk_i) begin
      if (init) begin
         stat_r <= `SSF_STATUS_RST;
         armed_r <= 5'h00;
      end else begin
         stat_r <= stat_nxt;
         armed_r <= armed_nxt;
      end
   end

   // control register
   always_ff @(posedge clk_i) begin
      if (init) begin
         ctrl_r <= `SSF_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxd_r <= 8'h00;
      end else if (rx_take && !ovr) begin
         rxd_r <= rx_char_i.data;
      end
   end

   // bus answer, one registered ack per request, one cycle after it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         ack_r <= acc;
         rdat_r <= hit_stat ? {24'h000000, stat_r}
            : hit_ctrl ? {24'h000000, ctrl_r} : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (init) begin
         start_r <= 1'b0;
         rxirq_r <= 1'b0;
         erirq_r <= 1'b0;
      end else begin
         start_r <= te && wclr[4] && !(sync_md && err_any);
         rxirq_r <= rie && stat_nxt[`SSF_RDF_BIT];
         erirq_r <= rie && |stat_nxt[5:3];
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign dat_o = rdat_r;
   assign ack_o = ack_r;
   assign tx_start_o = start_r;
   assign tx_mpbit_o = stat_r[`SSF_MPT_BIT];
   assign rx_data_o = rxd_r;
   assign rx_full_irq_o = rxirq_r;
   assign rx_error_irq_o = erirq_r;

   logic txok_r;
   logic rxok_r;
   wire ctrl_nxt_re = wr_ctrl ? dat_i[`SSF_RE_BIT] : re;
   always_ff @(posedge clk_i) begin
      if (init) begin
         txok_r <= 1'b0;
         rxok_r <= 1'b0;
      end else begin
         txok_r <= te && !(sync_md && |stat_nxt[5:3]);
         rxok_r <= ctrl_nxt_re && !(|stat_nxt[5:3]);
      end
   end
   assign tx_run_ok_o = txok_r;
   assign rx_run_ok_o = rxok_r;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   sequence armed_read_s;
      rd_stat && stat_r[`SSF_ORE_BIT];
   endsequence

   AST_RST_VAL: assert property (@(posedge clk_i)
      init |=> stat_r == `SSF_STATUS_RST) else $error("bad init value");
   AST_NO_SET: assert property (@(posedge clk_i) disable iff (init)
      !stat_r[`SSF_ORE_BIT] && !ovr |=> !stat_r[`SSF_ORE_BIT])
      else $error("overrun set without cause");
   AST_UNARMED: assert property (@(posedge clk_i) disable iff (init)
      stat_r[`SSF_FRE_BIT] && !armed_r[1] && !rd_stat
      |=> stat_r[`SSF_FRE_BIT]) else $error("unarmed clear");
   AST_ARM_CLR: assert property (@(posedge clk_i) disable iff (init)
      armed_read_s ##[2:4] (wr_stat && !dat_i[`SSF_ORE_BIT] && !ovr)
      |=> !stat_r[`SSF_ORE_BIT]) else $error("armed clear failed");
   AST_TX_END_FLAG_RO: assert property (@(posedge clk_i) disable iff (init)
      wr_stat && !wclr[4] && !te_fall && !tx_last_bit_i
      |=> $stable(stat_r[`SSF_TX_END_FLAG_BIT])) else $error("tx_end_flag written");
   AST_TDE_LOCK: assert property (@(posedge clk_i) disable iff (init)
      !te |=> stat_r[`SSF_TDE_BIT]) else $error("tx empty not locked");
   AST_GOOD: assert property (@(posedge clk_i) disable iff (init)
      good |=> stat_r[`SSF_RDF_BIT]) else $error("rx full not set");
   AST_DMA: assert property (@(posedge clk_i) disable iff (init)
      dma_rd_i && !good |=> !stat_r[`SSF_RDF_BIT]) else $error("dma clr");
   AST_OVR: assert property (@(posedge clk_i) disable iff (init)
      ovr |=> stat_r[`SSF_ORE_BIT] && $stable(rxd_r))
      else $error("overrun handling");
   AST_ERR_STOP: assert property (@(posedge clk_i) disable iff (init)
      err_any && !(|wclr[2:0]) |=> !rx_run_ok_o)
      else $error("rx runs on error");
   AST_ERR_RDF: assert property (@(posedge clk_i) disable iff (init)
      rx_take && frm_bad && !stat_r[`SSF_RDF_BIT] && !dma_rd_i
      |=> !stat_r[`SSF_RDF_BIT] && rxd_r == $past(rx_char_i.data))
      else $error("error char handling");
   // further flag and interrupt checks
   AST_RE_KEEP: assert property (@(posedge clk_i) disable iff (init)
      wr_ctrl && !dat_i[`SSF_RE_BIT] && !rx_take |=> $stable(stat_r[5:3]))
      else $error("rx disable changed error flags");
   AST_MPB_CAP: assert property (@(posedge clk_i) disable iff (init)
      rx_take && !ovr && mp_md && !sync_md
      |=> stat_r[`SSF_MPR_BIT] == $past(rx_char_i.mpbit)) else $error("mp bit");
   AST_TX_END_FLAG_CLR: assert property (@(posedge clk_i) disable iff (init)
      wclr[4] && te && !tx_last_bit_i |=> !stat_r[`SSF_TX_END_FLAG_BIT])
      else $error("tx end not cleared");
   AST_IRQ_DROP: assert property (@(posedge clk_i) disable iff (init)
      !rie |=> !rx_full_irq_o && !rx_error_irq_o)
      else $error("irq kept without enable");
   AST_TX_SET: assert property (@(posedge clk_i) disable iff (init)
      tx_load_i |=> stat_r[`SSF_TDE_BIT])
      else $error("tx empty not set on load");
   AST_PAR: assert property (@(posedge clk_i) disable iff (init)
      rx_take && !ovr && par_bad |=> stat_r[`SSF_PRE_BIT])
      else $error("parity flag not set");
endmodule : ssf_status

// ==== tb_serial_status_flags.sv ====
`timescale 1ns/1ps
module tb_serial_status_flags;
   import ssf_pkg::*;
   typedef struct packed {
      logic [7:0] ctrl;
      ssf_rxchar_s c;
      logic [7:0] st;
   } ssf_row_s;
   logic clk_i = 0, rst_i = 1, standby_i = 0, cyc_i = 0, stb_i = 0;
   logic we_i = 0, dma_rd_i = 0, slow_i = 0;
   logic [3:0] adr_i = '0, sel_i = '0;
   logic [31:0] dat_i = '0, dat_o, rd;
   logic ack_o, tx_load_i, tx_last_bit_i, tx_start_o, tx_mpbit_o;
   logic tx_run_ok_o, rx_done_i, rx_run_ok_o, rx_full_irq_o, rx_error_irq_o;
   logic [7:0] rx_data_o;
   ssf_rxchar_s rx_char_i;
   int n_errors = 0, cmp_count = 0, cyc_n = 0;
   // ctrl, char {data,parity,stop,mp}, status expected after it
   ssf_row_s rows [7] = '{{8'h02, {8'ha5, 3'b010}, 8'hc4},
      {8'h02, {8'h3c, 3'b110}, 8'h8c}, {8'h02, {8'h5a, 3'b000}, 8'h94},
      {8'h12, {8'h01, 3'b010}, 8'hc4}, {8'h06, {8'h3c, 3'b100}, 8'hc4},
      {8'h0a, {8'h7e, 3'b011}, 8'hc6}, {8'h0a, {8'h7e, 3'b010}, 8'hc4}};

   always #50 clk_i = ~clk_i;
   ssf_status i_ssf_status (.*);
   ssf_line_model i_ssf_line_model (.clk_i, .slow_i,
      .tx_start_i(tx_start_o), .tx_load_o(tx_load_i),
      .tx_last_bit_o(tx_last_bit_i), .rx_done_o(rx_done_i),
      .rx_char_o(rx_char_i));

   // compare and count
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic summarize;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   // one classic wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      if (k == 20) n_errors++;
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : wb
   task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(nm, rd, {24'h0, e});
   endtask : rdchk
   // read arms the flags, then zero write clears them
   task automatic clr;
      wb(1'b0, 4'h0, 8'h00);
      wb(1'b1, 4'h0, 8'h00);
   endtask : clr

   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk("reset", 4'h0, 8'h84);
      chk("mpbit", tx_mpbit_o, 0);
      wb(1'b1, 4'h0, 8'hff);
      rdchk("ones", 4'h0, 8'h85);
      chk("mpbit", tx_mpbit_o, 1);
      clr();
      rdchk("locked", 4'h0, 8'h84);
      wb(1'b1, 4'h8, 8'hff);
      rdchk("unmapped", 4'h8, 8'h00);
      foreach (rows[i]) begin
         wb(1'b1, 4'h4, rows[i].ctrl);
         i_ssf_line_model.send(rows[i].c);
         rdchk("rx status", 4'h0, rows[i].st);
         chk("rx data", rx_data_o, rows[i].c.data);
         clr();
      end
      i_ssf_line_model.send({8'h55, 3'b010});
      wb(1'b1, 4'h0, 8'h00);
      rdchk("unarmed", 4'h0, 8'hc4);
      clr();
      slow_i <= 1'b1;
      wb(1'b1, 4'h4, 8'h01);
      clr();
      rdchk("tx busy", 4'h0, 8'h00);
      repeat (12) @(posedge clk_i);
      rdchk("tx load", 4'h0, 8'h80);
      repeat (30) @(posedge clk_i);
      rdchk("tx end", 4'h0, 8'h84);
      slow_i <= 1'b0;
      clr();
      wb(1'b1, 4'h4, 8'h00);
      rdchk("te off", 4'h0, 8'h84);
      repeat (20) @(posedge clk_i);
      wb(1'b1, 4'h4, 8'h27);
      @(posedge clk_i);
      chk("tx run", tx_run_ok_o, 1);
      i_ssf_line_model.send({8'h11, 3'b010});
      i_ssf_line_model.send({8'h22, 3'b010});
      rdchk("overrun", 4'h0, 8'he4);
      chk("rx kept", rx_data_o, 8'h11);
      chk("runs", {tx_run_ok_o, rx_run_ok_o, rx_error_irq_o}, 3'b001);
      wb(1'b1, 4'h4, 8'h00);
      rdchk("re off", 4'h0, 8'he4);
      chk("irq", rx_error_irq_o, 0);
      @(posedge clk_i);
      dma_rd_i <= 1'b1;
      @(posedge clk_i);
      dma_rd_i <= 1'b0;
      rdchk("dma", 4'h0, 8'ha4);
      clr();
      wb(1'b1, 4'h4, 8'h02);
      rdchk("cleared", 4'h0, 8'h84);
      chk("rx run", rx_run_ok_o, 1);
      wb(1'b1, 4'h0, 8'h01);
      @(posedge clk_i);
      standby_i <= 1'b1;
      @(posedge clk_i);
      standby_i <= 1'b0;
      rdchk("standby", 4'h0, 8'h84);
      rdchk("ctrl", 4'h4, 8'h00);
      summarize();
   end

   // hang guard
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         n_errors++;
         summarize();
      end
   end
endmodule : tb_serial_status_flags
